// ---- rtl/amarit_core.sv ----
// address pointer update unit: reverse-carry, modulo and linear arithmetic
// Contract
// RL1 - modifier zero selects reverse-carry arithmetic
// RL2 - reverse-carry equals reversed add reversed back
// RL3 - offset 2^(k-1) steps k-bit reversed counter
// RL4 - modifier 1..32767 gives modulo modifier plus one
// RL5 - all-ones modifier gives linear wrap 65536
// RL6 - program never loads reserved modifier values
// RL7 - bit-reverse offset kept within 0..32K
// RL8 - program sets modifier, offset, pointer, post-increment
// RL9 - bit-reverse buffer aligned to 2^k
// RL10 - bit-reverse bounds: k low zeros to ones
// RL11 - present pointer first, update afterwards
// RL12 - modulo step past boundary wraps opposite
// RL13 - modulo base clears k low bits
// RL14 - block-multiple offset jumps P blocks linearly
// RL15 - program keeps modulo offset within modulus
// RL16 - mode decoded per pointer each update
`timescale 1ns/1ps
module amarit_core #(
  parameter int unsigned NPTR = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic upd_valid,
  input wire logic [$clog2(NPTR)-1:0] upd_sel,
  input wire logic upd_subtract,
  input wire logic [15:0] upd_offset,
  input wire logic ld_valid,
  input wire logic [$clog2(NPTR)-1:0] ld_sel,
  input wire logic [15:0] ld_pointer,
  input wire logic [15:0] ld_modifier,
  output logic [15:0] access_addr,
  output logic access_valid,
  output logic [1:0] access_kind
);
  localparam int unsigned SW = $clog2(NPTR);

  logic [15:0] ptr_r [NPTR];
  logic [15:0] ptr_nxt [NPTR];
  logic [15:0] mod_r [NPTR];
  logic [15:0] mod_nxt [NPTR];
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic val_r;
  logic val_nxt;
  logic [1:0] kind_r;
  logic [1:0] kind_nxt;

  function automatic amarit_pkg::amarit_kind_e decode_kind(input logic [15:0] m);
    if (m == amarit_pkg::MOD_REVERSE) begin
      decode_kind = amarit_pkg::AMARIT_REVERSE; // see RL1
    end else if (m <= amarit_pkg::MOD_MODULO_MAX) begin
      decode_kind = amarit_pkg::AMARIT_MODULO; // see RL4
    end else if (m == amarit_pkg::MOD_LINEAR) begin
      decode_kind = amarit_pkg::AMARIT_LINEAR; // see RL5
    end else begin
      decode_kind = amarit_pkg::AMARIT_RESERVED;
    end
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15-i];
    end
  endfunction

  // carry runs msb to lsb; subtraction adds the two's complement offset
  function automatic logic [15:0] rev_add(input logic [15:0] p, input logic [15:0] n, input logic sub);
    logic [15:0] rn;
    rn = rev16(n);
    if (sub) begin
      rn = 16'(~rn + 16'h0001);
    end
    rev_add = rev16(16'(rev16(p) + rn)); // see RL2 see RL3 see RL10
  endfunction

  // mask covering the k low bits, smallest 2^k not below modulus m+1
  function automatic logic [15:0] blk_mask(input logic [15:0] m);
    logic [15:0] r;
    r = m;
    for (int i = 1; i < 16; i = i * 2) begin
      r = r | (r >> i);
    end
    blk_mask = r;
  endfunction

  function automatic logic [15:0] mod_add(input logic [15:0] p, input logic [15:0] n, input logic [15:0] m,
                                          input logic sub);
    logic [15:0] mask;
    logic [15:0] base;
    logic [16:0] modulus;
    logic [16:0] rel;
    logic [16:0] mag;
    mask = blk_mask(m);
    base = p & ~mask; // see RL13
    modulus = {1'b0, m} + 17'h00001;
    rel = {1'b0, p & mask};
    mag = {1'b0, n};
    if ((n & mask) == 16'h0000 && n != 16'h0000) begin
      mod_add = sub ? 16'(p - n) : 16'(p + n); // see RL14
    end else if (!sub) begin
      rel = rel + mag;
      // past the upper bound folds back through the base
      if (rel >= modulus) begin
        rel = rel - modulus; // see RL12
      end
      mod_add = 16'(base + rel[15:0]);
    end else begin
      if (mag > rel) begin
        rel = rel + modulus - mag; // see RL12
      end else begin
        rel = rel - mag;
      end
      mod_add = 16'(base + rel[15:0]);
    end
  endfunction

  always_comb begin
    amarit_pkg::amarit_kind_e k;
    logic [15:0] cur;
    logic [15:0] m;
    k = amarit_pkg::AMARIT_LINEAR;
    cur = ptr_r[upd_sel];
    m = mod_r[upd_sel];
    ptr_nxt = ptr_r;
    mod_nxt = mod_r;
    addr_nxt = addr_r;
    val_nxt = 1'b0;
    kind_nxt = kind_r;
    if (upd_valid) begin
      k = decode_kind(m); // see RL16
      addr_nxt = cur; // see RL11
      val_nxt = 1'b1;
      kind_nxt = k;
      unique case (k)
        amarit_pkg::AMARIT_REVERSE: ptr_nxt[upd_sel] = rev_add(cur, upd_offset, upd_subtract);
        amarit_pkg::AMARIT_MODULO: ptr_nxt[upd_sel] = mod_add(cur, upd_offset, m, upd_subtract);
        amarit_pkg::AMARIT_LINEAR: ptr_nxt[upd_sel] = upd_subtract ? 16'(cur - upd_offset) : 16'(cur + upd_offset);
        // reserved codes leave the pointer untouched, a safe outcome for a misuse
        amarit_pkg::AMARIT_RESERVED: ptr_nxt[upd_sel] = cur;
      endcase
    end
    if (ld_valid) begin
      ptr_nxt[ld_sel] = ld_pointer;
      mod_nxt[ld_sel] = ld_modifier;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NPTR; i++) begin
        ptr_r[i] <= amarit_pkg::PTR_RESET;
        mod_r[i] <= amarit_pkg::MOD_LINEAR;
      end
      addr_r <= amarit_pkg::PTR_RESET;
      val_r <= 1'b0;
      kind_r <= amarit_pkg::AMARIT_LINEAR;
    end else begin
      ptr_r <= ptr_nxt;
      mod_r <= mod_nxt;
      addr_r <= addr_nxt;
      val_r <= val_nxt;
      kind_r <= kind_nxt;
    end
  end

  assign access_addr = addr_r;
  assign access_valid = val_r;
  assign access_kind = kind_r;

  logic [15:0] p_sel;
  assign p_sel = ptr_r[upd_sel];

  sequence s_update;
    upd_valid && !ld_valid;
  endsequence

  chk_present_first: assert property (@(posedge clk) disable iff (rst)
    s_update |=> access_valid && access_addr == $past(p_sel)) // see RL11
    else $error("access address not the pre-update pointer");

  chk_linear_wrap: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == amarit_pkg::MOD_LINEAR && !upd_subtract)
    |=> ptr_r[$past(upd_sel)] == 16'($past(p_sel) + $past(upd_offset))) // see RL5
    else $error("linear update wrong");

  chk_reverse_kind: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == amarit_pkg::MOD_REVERSE)
    |=> access_kind == amarit_pkg::AMARIT_REVERSE) // see RL1
    else $error("zero modifier not reverse carry");

  chk_reverse_step: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == amarit_pkg::MOD_REVERSE && !upd_subtract)
    |=> ptr_r[$past(upd_sel)] == rev16(16'(rev16($past(p_sel)) + rev16($past(upd_offset))))) // see RL2
    else $error("reverse carry sum wrong");

  chk_bitrev_order: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == amarit_pkg::MOD_REVERSE && upd_offset == 16'h0200 && p_sel == 16'h0c00
    && !upd_subtract)
    |=> ptr_r[$past(upd_sel)] == 16'h0e00) // see RL3
    else $error("bit reverse step wrong");

  chk_modulo_bound: assert property (@(posedge clk) disable iff (rst)
    s_update and (decode_kind(mod_r[upd_sel]) == amarit_pkg::AMARIT_MODULO
    && (p_sel & blk_mask(mod_r[upd_sel])) <= mod_r[upd_sel] && upd_offset <= mod_r[upd_sel])
    |=> (ptr_r[$past(upd_sel)] & ~blk_mask($past(mod_r[upd_sel]))) == ($past(p_sel) & ~blk_mask($past(mod_r[upd_sel])))
    && (ptr_r[$past(upd_sel)] & blk_mask($past(mod_r[upd_sel]))) <= $past(mod_r[upd_sel])) // see RL12
    else $error("modulo pointer left its buffer");

  chk_modulo_example: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == 16'h0014 && p_sel == 16'h004b && upd_offset == 16'h000f && !upd_subtract)
    |=> ptr_r[$past(upd_sel)] == 16'h0045) // see RL13
    else $error("modulo 21 example wrong");

  chk_block_jump: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] == 16'h0013 && upd_offset == 16'h0040 && !upd_subtract)
    |=> ptr_r[$past(upd_sel)] == 16'($past(p_sel) + 16'h0040)) // see RL14
    else $error("block multiple jump wrong");

  chk_per_pointer: assert property (@(posedge clk) disable iff (rst)
    s_update and (mod_r[upd_sel] >= 16'h0001 && mod_r[upd_sel] <= amarit_pkg::MOD_MODULO_MAX)
    |=> access_kind == amarit_pkg::AMARIT_MODULO) // see RL16 see RL4
    else $error("modulo decode wrong");
endmodule

// ---- inc/amarit_pkg.sv ----
// constants and types for the address modifier arithmetic block
package amarit_pkg;
  localparam int unsigned AW = 16;
  localparam logic [15:0] MOD_REVERSE = 16'h0000;
  localparam logic [15:0] MOD_LINEAR = 16'hffff;
  localparam logic [15:0] MOD_MODULO_MAX = 16'h7fff;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  typedef enum logic [1:0] {
    AMARIT_REVERSE = 2'b00,
    AMARIT_MODULO = 2'b01,
    AMARIT_LINEAR = 2'b10,
    AMARIT_RESERVED = 2'b11
  } amarit_kind_e;
endpackage

// ---- verification/amarit_dec_model.sv ----
// decode-side stand-in that issues pointer update requests
`timescale 1ns/1ps
module amarit_dec_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [19:0] cmd,
  output logic upd_valid,
  output logic [2:0] upd_sel,
  output logic upd_subtract,
  output logic [15:0] upd_offset
);
  always_ff @(posedge clk) begin // offset copied from cmd while go is high, inverted cmd otherwise
    {upd_valid, upd_sel, upd_subtract} <= {go, cmd[19:16]};
    upd_offset <= go ? cmd[15:0] : ~cmd[15:0];
  end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the pointer update arithmetic
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, ld_valid = 1'b0, upd_valid, upd_subtract, access_valid;
  logic [2:0] ld_sel = 3'h0, upd_sel;
  logic [15:0] ld_pointer = 16'h0, ld_modifier = 16'h0, upd_offset, access_addr;
  logic [19:0] cmd = 20'h0, dq [$];
  logic [1:0] access_kind;
  logic [17:0] eq [$];
  int error_cnt = 0, checked = 0;
  amarit_dec_model dec (.clk(clk), .go(go), .cmd(cmd), .upd_valid(upd_valid), .upd_sel(upd_sel),
    .upd_subtract(upd_subtract), .upd_offset(upd_offset));
  amarit_core #(.NPTR(8)) uut (.clk(clk), .rst(rst), .upd_valid(upd_valid), .upd_sel(upd_sel),
    .upd_subtract(upd_subtract), .upd_offset(upd_offset), .ld_valid(ld_valid), .ld_sel(ld_sel),
    .ld_pointer(ld_pointer), .ld_modifier(ld_modifier), .access_addr(access_addr),
    .access_valid(access_valid), .access_kind(access_kind));
  initial forever #4 clk = ~clk;
  task automatic chk(string name, logic [15:0] seen, logic [15:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (access_valid === 1'b1 && eq.size() > 0) begin
      chk("addr", access_addr, eq[0][15:0]);
      chk("kind", 16'(access_kind), 16'(eq[0][17:16]));
      void'(eq.pop_front());
    end else if (access_valid !== 1'b0) chk("valid", 16'(access_valid), 16'h0);
  end
  task automatic ld(logic [2:0] s, logic [15:0] p, logic [15:0] m);
    @(posedge clk);
    {ld_valid, ld_sel, ld_pointer, ld_modifier} <= {1'b1, s, p, m};
    @(posedge clk);
    ld_valid <= 1'b0;
  endtask
  task automatic u(logic [2:0] s, logic sub, logic [15:0] o, logic [1:0] k, logic [15:0] a);
    dq.push_back({s, sub, o});
    eq.push_back({k, a});
  endtask
  // requests go out back to back; the bound cuts a stalled design short
  task automatic run(string name);
    for (int i = 0; i < 40 && eq.size() > 0; i++) begin
      @(posedge clk);
      go <= dq.size() > 0;
      if (dq.size() > 0) cmd <= dq.pop_front();
    end
    chk("pending", 16'(eq.size()), 16'h0);
    if (eq.size() > 0) final_report();
    else $display("test %s done", name);
  endtask
  task automatic t_mixed();
    chk("reset addr", access_addr, 16'h0);
    chk("reset flags", 16'({access_kind, access_valid}), 16'h4);
    ld(3'h0, 16'hfffe, 16'hffff);
    ld(3'h1, 16'ha, 16'h3);
    u(3'h0, 1'h0, 16'h5, 2'h2, 16'hfffe);
    u(3'h1, 1'h0, 16'h3, 2'h1, 16'ha);
    u(3'h0, 1'h1, 16'h3, 2'h2, 16'h3);
    u(3'h1, 1'h0, 16'h0, 2'h1, 16'h9);
    run("mixed");
  endtask
  task automatic t_modulo();
    ld(3'h2, 16'h50, 16'h13);
    ld(3'h5, 16'h4b, 16'h14);
    u(3'h2, 1'h0, 16'h5, 2'h1, 16'h50);
    u(3'h2, 1'h1, 16'h5, 2'h1, 16'h41);
    u(3'h2, 1'h0, 16'h40, 2'h1, 16'h50);
    u(3'h2, 1'h0, 16'h0, 2'h1, 16'h90);
    u(3'h5, 1'h0, 16'hf, 2'h1, 16'h4b);
    u(3'h5, 1'h0, 16'h0, 2'h1, 16'h45);
    run("modulo");
  endtask
  task automatic t_reverse();
    ld(3'h3, 16'hc00, 16'h0);
    u(3'h3, 1'h0, 16'h200, 2'h0, 16'hc00);
    u(3'h3, 1'h0, 16'h200, 2'h0, 16'he00);
    u(3'h3, 1'h0, 16'h0, 2'h0, 16'hd00);
    u(3'h3, 1'h0, 16'h200, 2'h0, 16'hd00);
    u(3'h3, 1'h0, 16'h200, 2'h0, 16'hf00);
    u(3'h3, 1'h0, 16'h200, 2'h0, 16'hc80);
    u(3'h3, 1'h1, 16'h200, 2'h0, 16'he80);
    u(3'h3, 1'h0, 16'h0, 2'h0, 16'hc80);
    run("reverse");
  endtask
  task automatic t_reserved();
    ld(3'h4, 16'h1234, 16'h8000);
    u(3'h4, 1'h0, 16'h5, 2'h3, 16'h1234);
    u(3'h4, 1'h0, 16'h5, 2'h3, 16'h1234);
    run("reserved");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_mixed();
    t_modulo();
    t_reverse();
    t_reserved();
    final_report();
  end
endmodule
